/* File: ssa_top.sv */
// The implementer's own choices: the register offsets and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module ssa_top #(
  parameter int ADDR_W = 4
) (
  input  wire logic              clk_sys,
  input  wire logic              rst,
  input  wire logic              ce,
  input  wire ssa_pkg::ssa_bus_req_t bus_req,
  output logic [7:0]             rdata,
  input  wire ssa_pkg::ssa_pins_t pins_in,
  input  wire logic              master_mode,
  output logic                   sda_out,
  output logic                   sda_oe,
  output logic                   serial_event,
  output logic                   irq
);

  //--------------------------------------------------------------------
  // Elaboration check
  //--------------------------------------------------------------------
  if (ADDR_W != 4) begin : g_bad_width
    $error("ADDR_W must be 4");
  end

  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_ACK, ST_SLAVE, ST_SKIP} ssa_state_t;

  //--------------------------------------------------------------------
  // Pin synchronisers
  //--------------------------------------------------------------------
  ssa_pkg::ssa_pins_t sync1_ff;
  ssa_pkg::ssa_pins_t sync2_ff;
  ssa_pkg::ssa_pins_t prev_ff;
  ssa_pkg::ssa_pins_t nxt_sync1;
  ssa_pkg::ssa_pins_t nxt_sync2;
  ssa_pkg::ssa_pins_t nxt_prev;

  // Two-stage capture, then one stage for edge detection
  always_comb begin
    nxt_sync1 = sync1_ff;
    nxt_sync2 = sync2_ff;
    nxt_prev  = prev_ff;
    if (ce) begin
      nxt_sync1 = pins_in;
      nxt_sync2 = sync1_ff;
      nxt_prev  = sync2_ff;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sync1_ff <= '1;
      sync2_ff <= '1;
      prev_ff  <= '1;
    end else begin
      sync1_ff <= nxt_sync1;
      sync2_ff <= nxt_sync2;
      prev_ff  <= nxt_prev;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  // Bus conditions seen on the synchronised lines
  assign scl_rise  = sync2_ff.scl & ~prev_ff.scl;
  assign scl_fall  = ~sync2_ff.scl & prev_ff.scl;
  assign start_det = sync2_ff.scl & prev_ff.scl & prev_ff.sda & ~sync2_ff.sda;
  assign stop_det  = sync2_ff.scl & prev_ff.scl & ~prev_ff.sda & sync2_ff.sda;

  //--------------------------------------------------------------------
  // Link state machine and state code
  //--------------------------------------------------------------------
  ssa_state_t st_ff;
  ssa_state_t nxt_st;
  logic [7:0] sh_ff;
  logic [7:0] nxt_sh;
  logic [3:0] cnt_ff;
  logic [3:0] nxt_cnt;
  logic [4:0] code_ff;
  logic [4:0] nxt_code;
  logic [7:0] own_addr_ff;
  logic [3:0] ev_set;

  logic eval;
  logic is_gc_addr;
  logic own_hit;
  logic gc_hit;

  // Address byte complete on the falling edge after the eighth bit
  assign eval = ce & (st_ff == ST_ADDR) & scl_fall & ~start_det & ~stop_det
              & (cnt_ff == 4'(ssa_pkg::BITS_PER_BYTE));
  assign is_gc_addr = (sh_ff[7:1] == ssa_pkg::GC_ADDR);
  assign own_hit = ~master_mode & ~is_gc_addr
                 & (sh_ff[7:1] == own_addr_ff[ssa_pkg::ADDR_MSB:ssa_pkg::ADDR_LSB]);
  assign gc_hit = ~master_mode & is_gc_addr & ~sh_ff[0]
                & own_addr_ff[ssa_pkg::GC_EN_BIT];

  always_comb begin
    nxt_st   = st_ff;
    nxt_sh   = sh_ff;
    nxt_cnt  = cnt_ff;
    nxt_code = code_ff;
    ev_set   = '0;
    if (ce) begin
      if (start_det) begin
        nxt_st  = ST_ADDR;
        nxt_cnt = '0;
      end else if (stop_det) begin
        if (st_ff == ST_SLAVE || st_ff == ST_ACK) begin
          nxt_code              = ssa_pkg::CODE_STOP[7:3];
          ev_set[ssa_pkg::EV_STOP] = 1'b1;
        end
        nxt_st = ST_IDLE;
      end else begin
        case (st_ff)
          ST_ADDR: begin
            if (scl_rise && cnt_ff < 4'(ssa_pkg::BITS_PER_BYTE)) begin
              nxt_sh  = {sh_ff[6:0], sync2_ff.sda};
              nxt_cnt = cnt_ff + 4'h1;
            end
            if (eval) begin
              if (own_hit) begin
                nxt_st = ST_ACK;
                if (sh_ff[0]) begin
                  nxt_code                  = ssa_pkg::CODE_OWN_R[7:3];
                  ev_set[ssa_pkg::EV_OWN_R] = 1'b1;
                end else begin
                  nxt_code                  = ssa_pkg::CODE_OWN_W[7:3];
                  ev_set[ssa_pkg::EV_OWN_W] = 1'b1;
                end
              end else if (gc_hit) begin
                nxt_st                 = ST_ACK;
                nxt_code               = ssa_pkg::CODE_GC[7:3];
                ev_set[ssa_pkg::EV_GC] = 1'b1;
              end else begin
                nxt_st = ST_SKIP;
              end
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              nxt_st = ST_SLAVE;
            end
          end
          ST_IDLE, ST_SLAVE, ST_SKIP: begin
            nxt_st = st_ff;
          end
          default: begin
            nxt_st = ST_IDLE;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_ff   <= ST_IDLE;
      sh_ff   <= '0;
      cnt_ff  <= '0;
      code_ff <= ssa_pkg::CODE_IDLE[7:3];
    end else begin
      st_ff   <= nxt_st;
      sh_ff   <= nxt_sh;
      cnt_ff  <= nxt_cnt;
      code_ff <= nxt_code;
    end
  end

  // Acknowledge drives SDA low for the ninth clock
  assign sda_out = 1'b0;
  assign sda_oe  = (st_ff == ST_ACK);

  //--------------------------------------------------------------------
  // Register file and interrupt
  //--------------------------------------------------------------------
  logic [7:0] nxt_own_addr;
  logic [3:0] ev_stat_ff;
  logic [3:0] nxt_ev_stat;
  logic [3:0] ev_mask_ff;
  logic [3:0] nxt_ev_mask;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic [7:0] code_rd;

  assign code_rd = {code_ff, 3'b000};

  always_comb begin
    nxt_own_addr = own_addr_ff;
    nxt_ev_stat  = ev_stat_ff;
    nxt_ev_mask  = ev_mask_ff;
    nxt_rdata    = rdata_ff;
    if (ce) begin
      if (bus_req.wr) begin
        case (bus_req.addr)
          ssa_pkg::OFS_OWN_ADDR: nxt_own_addr = bus_req.wdata;
          ssa_pkg::OFS_EV_STAT:  nxt_ev_stat  = ev_stat_ff & ~bus_req.wdata[3:0];
          ssa_pkg::OFS_EV_MASK:  nxt_ev_mask  = bus_req.wdata[3:0];
          default:               nxt_own_addr = own_addr_ff;
        endcase
      end
      // Hardware set wins over write-one clear
      nxt_ev_stat = nxt_ev_stat | ev_set;
      if (bus_req.rd) begin
        case (bus_req.addr)
          ssa_pkg::OFS_OWN_ADDR: nxt_rdata = own_addr_ff;
          ssa_pkg::OFS_CODE:     nxt_rdata = code_rd;
          ssa_pkg::OFS_EV_STAT:  nxt_rdata = {4'h0, ev_stat_ff};
          ssa_pkg::OFS_EV_MASK:  nxt_rdata = {4'h0, ev_mask_ff};
          default:               nxt_rdata = 8'h00;
        endcase
      end else begin
        nxt_rdata = 8'h00;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      own_addr_ff <= ssa_pkg::RST_OWN_ADDR;
      ev_stat_ff  <= ssa_pkg::RST_EV;
      ev_mask_ff  <= ssa_pkg::RST_EV;
      rdata_ff    <= 8'h00;
    end else begin
      own_addr_ff <= nxt_own_addr;
      ev_stat_ff  <= nxt_ev_stat;
      ev_mask_ff  <= nxt_ev_mask;
      rdata_ff    <= nxt_rdata;
    end
  end

  assign serial_event = |ev_stat_ff;
  assign irq          = |(ev_stat_ff & ev_mask_ff);
  assign rdata        = rdata_ff;

  //--------------------------------------------------------------------
  // Assertions
  //--------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  property p_low_zero;
    (ce && bus_req.rd && bus_req.addr == ssa_pkg::OFS_CODE && serial_event)
      |=> (rdata[2:0] == 3'b000);
  endproperty
  a_low_zero: assert property (p_low_zero) else $error("code low bits not zero");

  property p_master_skip;
    (eval && master_mode) |=> (st_ff == ST_SKIP) && !sda_oe;
  endproperty
  a_master_skip: assert property (p_master_skip) else $error("master mode matched");

  property p_own_w;
    (eval && own_hit && !sh_ff[0]) |=> (code_rd == ssa_pkg::CODE_OWN_W)
      && ev_stat_ff[ssa_pkg::EV_OWN_W] && sda_oe;
  endproperty
  a_own_w: assert property (p_own_w) else $error("own write code wrong");

  property p_gc;
    (eval && gc_hit) |=> (code_rd == ssa_pkg::CODE_GC) && sda_oe;
  endproperty
  a_gc: assert property (p_gc) else $error("general call code wrong");

  property p_gc_off;
    (eval && is_gc_addr && !own_addr_ff[ssa_pkg::GC_EN_BIT]) |=> (st_ff == ST_SKIP);
  endproperty
  a_gc_off: assert property (p_gc_off) else $error("general call not ignored");

  property p_no_match;
    (eval && !own_hit && !gc_hit) |=> !sda_oe [*2];
  endproperty
  a_no_match: assert property (p_no_match) else $error("ack without match");

  property p_start;
    (ce && start_det) |=> (st_ff == ST_ADDR) && (cnt_ff == 4'h0);
  endproperty
  a_start: assert property (p_start) else $error("start not restarting");

  property p_rd_code;
    (ce && bus_req.rd && bus_req.addr == ssa_pkg::OFS_CODE) |=> (rdata == $past(code_rd));
  endproperty
  a_rd_code: assert property (p_rd_code) else $error("code readback wrong");

  property p_own_field;
    (eval && !master_mode && !is_gc_addr && sh_ff[7:1] == own_addr_ff[7:1])
      |=> (st_ff == ST_ACK);
  endproperty
  a_own_field: assert property (p_own_field) else $error("own address missed");

  c_own_w: cover property (eval && own_hit && !sh_ff[0]);
  c_gc:    cover property (eval && gc_hit);
  c_stop:  cover property (ce && stop_det && st_ff == ST_SLAVE);
  c_irq:   cover property (irq);

endmodule
`default_nettype wire

/* File: ssa_pkg.sv */
//----------------------------------------------------------------------
// Overview of operation
//----------------------------------------------------------------------
// Overview of operation
// - Slave address is the upper seven bits of the own address register.
// - Bit 0 set recognises general call address zero; clear ignores it.
// - In master operation the whole own address register is disregarded.
// - Slave response happens only when the received address matches.
// - Stored address MSB compares with first received bit, then in order.
// - An 8-bit state code register reports distinct codes per state.
// - While the event flag is set, state code bits 2 to 0 read zero.
// - State code is valid only while the serial event flag is set.
// - Own address with write direction acknowledged reports code 0x60.
// - General call address acknowledged reports code 0x70.
`default_nettype none
package ssa_pkg;

  //--------------------------------------------------------------------
  // Register offsets
  //--------------------------------------------------------------------
  localparam logic [3:0] OFS_OWN_ADDR = 4'h0;
  localparam logic [3:0] OFS_CODE     = 4'h1;
  localparam logic [3:0] OFS_EV_STAT  = 4'h2;
  localparam logic [3:0] OFS_EV_MASK  = 4'h3;

  //--------------------------------------------------------------------
  // Fields and reset values
  //--------------------------------------------------------------------
  localparam int         GC_EN_BIT    = 0;
  localparam int         ADDR_MSB     = 7;
  localparam int         ADDR_LSB     = 1;
  localparam logic [6:0] GC_ADDR      = 7'h00;
  localparam logic [7:0] RST_OWN_ADDR = 8'h00;
  localparam logic [3:0] RST_EV       = 4'h0;
  localparam int         EV_OWN_W     = 0;
  localparam int         EV_OWN_R     = 1;
  localparam int         EV_GC        = 2;
  localparam int         EV_STOP      = 3;

  //--------------------------------------------------------------------
  // State codes (only bits 7..3 stored)
  //--------------------------------------------------------------------
  localparam logic [7:0] CODE_IDLE    = 8'hf8;
  localparam logic [7:0] CODE_OWN_W   = 8'h60;
  localparam logic [7:0] CODE_GC      = 8'h70;
  localparam logic [7:0] CODE_STOP    = 8'ha0;
  localparam logic [7:0] CODE_OWN_R   = 8'ha8;

  //--------------------------------------------------------------------
  // Timing
  //--------------------------------------------------------------------
  localparam int SYS_PERIOD_NS  = 4;
  localparam int LINK_PERIOD_NS = 32;
  localparam int SYNC_STAGES    = 2;
  localparam int BITS_PER_BYTE  = 8;

  //--------------------------------------------------------------------
  // Carriers
  //--------------------------------------------------------------------
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } ssa_bus_req_t;

  typedef struct packed {
    logic scl;
    logic sda;
  } ssa_pins_t;

endpackage
`default_nettype wire

/* File: ssa_link_master.sv */
`timescale 1ns/1ps
`default_nettype none
module ssa_link_master (
  output var logic  scl,
  output var logic  sda_rel,
  input  wire logic sda_wire
);
  localparam int HALF = ssa_pkg::LINK_PERIOD_NS / 2;

  // Idle bus: both lines released high
  initial begin
    scl = 1'b1;
    sda_rel = 1'b1;
  end

  // Start or repeated start, data falls while clock high
  task automatic start();
    #1;
    sda_rel = 1'b1;
    #HALF;
    scl = 1'b1;
    #HALF;
    sda_rel = 1'b0;
    #HALF;
    scl = 1'b0;
  endtask

  task automatic send(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda_rel = b[i];
      #(HALF / 2);
      scl = 1'b1;
      #HALF;
      scl = 1'b0;
      #(HALF / 2);
    end
    sda_rel = 1'b1;       // Release for the acknowledge
    #(2 * HALF);
    scl = 1'b1;
    #(HALF / 2);
    ack = ~sda_wire;      // Low wire means acknowledged
    #(HALF / 2);
    scl = 1'b0;
    #HALF;
  endtask

  // Stop, data rises while clock high
  task automatic stop();
    sda_rel = 1'b0;
    #HALF;
    scl = 1'b1;
    #HALF;
    sda_rel = 1'b1;
    #HALF;
  endtask
endmodule
`default_nettype wire

/* File: smbus_slave_address_and_status_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module smbus_slave_address_and_status_bench;
  logic                  clk_sys     = 1'b0;
  logic                  rst         = 1'b1;
  logic                  master_mode = 1'b0;
  logic                  ce          = 1'b1;
  ssa_pkg::ssa_bus_req_t bus_req     = '0;
  ssa_pkg::ssa_pins_t    pins_in;
  logic [7:0]            rdata;
  logic                  sda_out;
  logic                  sda_oe;
  logic                  serial_event;
  logic                  irq;
  logic                  scl;
  logic                  sda_rel;
  logic                  sda_wire;
  int                    errors      = 0;
  int                    compares    = 0;

  // Open-drain wire with pull-up
  assign sda_wire = sda_rel & ~(sda_oe & ~sda_out);
  assign pins_in = {scl, sda_wire};

  // System clock
  always #(ssa_pkg::SYS_PERIOD_NS / 2) clk_sys = ~clk_sys;

  ssa_top dut (
    .clk_sys      (clk_sys),
    .rst          (rst),
    .ce           (ce),
    .bus_req      (bus_req),
    .rdata        (rdata),
    .pins_in      (pins_in),
    .master_mode  (master_mode),
    .sda_out      (sda_out),
    .sda_oe       (sda_oe),
    .serial_event (serial_event),
    .irq          (irq)
  );

  ssa_link_master m (
    .scl      (scl),
    .sda_rel  (sda_rel),
    .sda_wire (sda_wire)
  );

  task automatic final_report();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_sys);
    bus_req <= '0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk_sys);
    bus_req <= '0;
    #1;
    check(rdata, exp);
  endtask

  task automatic addr_byte(input logic [7:0] own, input logic mm, input logic [7:0] b,
                           input logic exp_ack, input logic [7:0] exp_stat);
    logic ack;
    wr_reg(ssa_pkg::OFS_OWN_ADDR, own);
    master_mode <= mm;
    m.start();
    m.send(b, ack);
    repeat (4) @(posedge clk_sys);
    check({7'h00, ack}, {7'h00, exp_ack});
    rd_chk(ssa_pkg::OFS_EV_STAT, exp_stat);
    check({7'h00, serial_event}, {7'h00, exp_stat != 8'h00});
  endtask

  // Stop, then clear all events and see the flag drop
  task automatic end_case(input logic [7:0] exp_stat);
    m.stop();
    repeat (4) @(posedge clk_sys);
    rd_chk(ssa_pkg::OFS_EV_STAT, exp_stat);
    if (exp_stat[ssa_pkg::EV_STOP]) rd_chk(ssa_pkg::OFS_CODE, ssa_pkg::CODE_STOP);
    wr_reg(ssa_pkg::OFS_EV_STAT, 8'h0f);
    repeat (2) @(posedge clk_sys);
    check({7'h00, serial_event}, 8'h00);
  endtask

  task automatic t_reset();
    rd_chk(ssa_pkg::OFS_OWN_ADDR, 8'h00);
    rd_chk(ssa_pkg::OFS_CODE, 8'hf8);
    @(posedge clk_sys);
    #1;
    check(rdata, 8'h00);
    check({6'h00, serial_event, irq}, 8'h00);
  endtask

  // Clock enable low freezes the registers
  task automatic t_freeze();
    wr_reg(ssa_pkg::OFS_OWN_ADDR, 8'h62);
    ce <= 1'b0;
    wr_reg(ssa_pkg::OFS_OWN_ADDR, 8'h5a);
    @(posedge clk_sys);
    ce <= 1'b1;
    rd_chk(ssa_pkg::OFS_OWN_ADDR, 8'h62);
  endtask

  task automatic t_own_write();
    addr_byte(8'h62, 1'b0, 8'h62, 1'b1, 8'h01);
    rd_chk(ssa_pkg::OFS_CODE, 8'h60);
    end_case(8'h09);
  endtask

  task automatic t_order();
    addr_byte(8'h62, 1'b0, 8'h8c, 1'b0, 8'h00);
    addr_byte(8'h62, 1'b0, 8'h63, 1'b1, 8'h02);
    rd_chk(ssa_pkg::OFS_CODE, 8'ha8);
    end_case(8'h0a);
  endtask

  task automatic t_general_call();
    addr_byte(8'h62, 1'b0, 8'h00, 1'b0, 8'h00);
    addr_byte(8'h63, 1'b0, 8'h00, 1'b1, 8'h04);
    rd_chk(ssa_pkg::OFS_CODE, 8'h70);
    end_case(8'h0c);
  endtask

  task automatic t_master();
    addr_byte(8'h63, 1'b1, 8'h62, 1'b0, 8'h00);
    addr_byte(8'h63, 1'b1, 8'h00, 1'b0, 8'h00);
    end_case(8'h00);
    master_mode <= 1'b0;
  endtask

  task automatic t_irq();
    wr_reg(ssa_pkg::OFS_EV_MASK, 8'h01);
    addr_byte(8'h62, 1'b0, 8'h62, 1'b1, 8'h01);
    check({7'h00, irq}, 8'h01);
    wr_reg(ssa_pkg::OFS_EV_MASK, 8'h00);
    @(posedge clk_sys);
    #1;
    check({6'h00, serial_event, irq}, 8'h02);
    wr_reg(ssa_pkg::OFS_EV_MASK, 8'h01);
    wr_reg(ssa_pkg::OFS_EV_STAT, 8'h01);
    @(posedge clk_sys);
    #1;
    check({6'h00, serial_event, irq}, 8'h00);
    end_case(8'h08);
  endtask

  // Main sequence; the code register is never written
  // software leaves code alone
  initial begin
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset();
    t_freeze();
    t_own_write();
    t_order();
    t_general_call();
    t_master();
    t_irq();
    final_report();
  end

  // Watchdog against a hang
  initial begin
    #100000;
    errors++;
    final_report();
  end
endmodule
`default_nettype wire
